// ===== rtl/acs_regs.svh
// Purpose: timing counts, reset values and code limits of the sequencer
// Assumes: master clock is clk_i; one count per master clock cycle
// Notes:   definitions only
// Behaviour
// - host resets; reset alone starts no calibration
// - reset clears offset, loads unity gain
// - calibrate-request high at reset release runs calibration
// - calibration lasts 327680 cycles, then ready falls
// - idle calibrate-request rise starts calibration, ready falls
// - offset with inputs shorted, then gain on reference
// - offset and gain corrections applied to results
// - start-request low begins a conversion
// - start held low: result every 160 cycles
// - ready tied to start: conversion every 162 cycles
// - asynchronous start adds 0-2 cycles, 164 max
// - finished conversion loads result and drops ready
// - ready rises on readout or, with chip select low, two cycles early
// - clock pin held low selects oscillator, toggling selects external clock
// - clock pin held high suspends operation
// - range select input picks the result coding
// - bipolar clamps 8000..7FFF, unipolar 0000..FFFF
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_CAL_CYCLES     327680
`define ACS_SAMPLE_CYCLES  160
`define ACS_READY_LEAD     2
`define ACS_HOLD_CYCLES    8
`define ACS_OFFSET_RESET   16'h0000
`define ACS_GAIN_UNITY     17'h1_0000
`define ACS_GAIN_MAX       17'h1_FFFF
`define ACS_GAIN_TARGET    19'h0_8000
`define ACS_BIP_MAX        16'h7FFF
`define ACS_BIP_MIN        16'h8000
`define ACS_UNI_FLIP       16'h8000
`endif

// ===== rtl/acs_pkg.sv
// Purpose: types shared by the sequencer modules
// Assumes: numbers live in acs_regs.svh
// Notes:   one packed state struct per clocked module
package acs_pkg;
    typedef enum logic [2:0] {
        PH_RESET,
        PH_CAL_OFS,
        PH_CAL_GAIN,
        PH_IDLE,
        PH_ARM,
        PH_SAMPLE
    } acs_phase_e;

    typedef struct packed {
        logic signed [15:0] offset;
        logic [16:0]        gain;
    } acs_corr_s;

    typedef struct packed {
        acs_phase_e  phase;
        logic [18:0] count;
        acs_corr_s   corr;
        logic        cal_prev;
        logic        ready_n;
        logic [15:0] result;
        logic        short_in;
        logic        ref_in;
        logic        calibrated;
        logic        busy;
    } acs_state_s;

    typedef struct packed {
        logic       pin_prev;
        logic [3:0] cnt;
        logic       osc_en;
        logic       hold;
    } acs_clksrc_s;
endpackage

// ===== rtl/acs_clk_source.sv
// Purpose: watch the master clock pin level, pick the clock source
// Assumes: pin sampled as a synchronous level
// Notes:   toggling pin means external clock, oscillator off
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_clk_source #(
    parameter int HOLD_CYCLES = `ACS_HOLD_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic mclk_pin_i,
    output logic      osc_enable_o,
    output logic      clock_hold_o
);
    import acs_pkg::*;

    localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES);

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 15) begin : g_bad_hold
        $error("HOLD_CYCLES must lie in 1..15");
    end

    acs_clksrc_s s;
    acs_clksrc_s next_s;

    always_comb begin
        next_s = s;
        next_s.pin_prev = mclk_pin_i;
        if (mclk_pin_i != s.pin_prev) begin
            next_s.cnt    = '0;
            next_s.osc_en = 1'b0;
            next_s.hold   = 1'b0;
        end else if (s.cnt != HOLD_LAST) begin
            next_s.cnt = s.cnt + 4'h1;
        end else begin
            next_s.osc_en = ~mclk_pin_i;
            next_s.hold   = mclk_pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign osc_enable_o = s.osc_en;
    assign clock_hold_o = s.hold;

    a_pin_high_hold : assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (s.cnt == HOLD_LAST && s.pin_prev && mclk_pin_i)
            |=> clock_hold_o && !osc_enable_o)
        else $error("pin held high did not suspend");
endmodule

// ===== rtl/acs_correct.sv
// Purpose: apply offset and gain, clamp and code a raw sample
// Assumes: gain is unsigned with 16 fraction bits
// Notes:   purely combinational
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_correct (
    input  wire logic signed [15:0] raw_i,
    input  wire acs_pkg::acs_corr_s corr_i,
    input  wire logic               signed_range_select_i,
    output logic [15:0]             code_o
);
    import acs_pkg::*;

    logic signed [16:0] diff;
    logic signed [34:0] prod;
    logic signed [18:0] scaled;
    logic [15:0]        clamped;

    always_comb begin
        diff   = {raw_i[15], raw_i} - {corr_i.offset[15], corr_i.offset};
        prod   = diff * $signed({1'b0, corr_i.gain});
        scaled = prod[34:16];
        if (scaled > $signed({3'b000, `ACS_BIP_MAX})) begin
            clamped = `ACS_BIP_MAX;
        end else if (scaled < $signed({3'b111, `ACS_BIP_MIN})) begin
            clamped = `ACS_BIP_MIN;
        end else begin
            clamped = scaled[15:0];
        end
        if (signed_range_select_i) begin
            code_o = clamped;
        end else begin
            code_o = clamped ^ `ACS_UNI_FLIP;
        end
    end
endmodule

// ===== rtl/acs_sequencer.sv
// Purpose: reset, calibration and conversion sequencing of the converter
// Assumes: inputs synchronous to clk_i; raw_sample_i is filter output
// Notes:   serial shifting lives outside; word_read_i marks it empty
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_sequencer #(
    parameter int CAL_CYCLES  = `ACS_CAL_CYCLES,
    parameter int HOLD_CYCLES = `ACS_HOLD_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cal_req_i,
    input  wire logic        start_sample_n_i,
    input  wire logic        signed_range_select_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        word_read_i,
    input  wire logic [15:0] raw_sample_i,
    input  wire logic        mclk_pin_i,
    output logic             data_ready_n_o,
    output logic [15:0]      result_o,
    output logic             short_inputs_o,
    output logic             ref_to_input_o,
    output logic             osc_enable_o,
    output logic             calibrated_o,
    output logic             busy_o
);
    import acs_pkg::*;

    localparam logic [18:0] CAL_HALF_M1 = 19'(CAL_CYCLES / 2 - 1);
    localparam logic [18:0] SAMPLE_M1   = 19'(`ACS_SAMPLE_CYCLES - 1);
    localparam logic [18:0] LEAD_AT     =
        19'(`ACS_SAMPLE_CYCLES - 1 - `ACS_READY_LEAD);
    localparam logic [19:0] CAL_TOTAL   = 20'(CAL_CYCLES);
    localparam logic [19:0] CAL_HALF    = 20'(CAL_CYCLES / 2);

    localparam acs_state_s RESET_ST = '{
        phase:      PH_RESET,
        count:      '0,
        corr:       '{offset: `ACS_OFFSET_RESET, gain: `ACS_GAIN_UNITY},
        cal_prev:   1'b0,
        ready_n:    1'b1,
        result:     '0,
        short_in:   1'b0,
        ref_in:     1'b0,
        calibrated: 1'b0,
        busy:       1'b1
    };

    if (CAL_CYCLES < 4 || CAL_CYCLES >= 2**19 || CAL_CYCLES % 2 != 0)
    begin : g_bad_cal
        $error("CAL_CYCLES must be even and within 4..2^19-1");
    end

    // reset release through two flops
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    logic        clock_hold;
    logic [15:0] code;

    acs_clk_source #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_clk_source (
        .clk_i        (clk_i),
        .rst_n_i      (rst_sync_n),
        .mclk_pin_i   (mclk_pin_i),
        .osc_enable_o (osc_enable_o),
        .clock_hold_o (clock_hold)
    );

    acs_state_s s;
    acs_state_s next_s;

    acs_correct u_correct (
        .raw_i                 (raw_sample_i),
        .corr_i                (s.corr),
        .signed_range_select_i (signed_range_select_i),
        .code_o                (code)
    );

    // gain estimate from the reference measurement
    logic signed [16:0] meas;
    logic signed [18:0] gcalc;
    logic [16:0]        new_gain;

    always_comb begin
        meas  = {raw_sample_i[15], raw_sample_i}
              - {s.corr.offset[15], s.corr.offset};
        gcalc = 19'sh1_0000
              + (($signed(`ACS_GAIN_TARGET) - {{2{meas[16]}}, meas}) <<< 1);
        if (gcalc < 0) begin
            new_gain = '0;
        end else if (gcalc > $signed({2'b00, `ACS_GAIN_MAX})) begin
            new_gain = `ACS_GAIN_MAX;
        end else begin
            new_gain = gcalc[16:0];
        end
    end

    always_comb begin
        next_s = s;
        if (word_read_i && !s.ready_n) begin
            next_s.ready_n = 1'b1;
        end
        if (!clock_hold) begin
            next_s.cal_prev = cal_req_i;
            case (s.phase)
                PH_RESET: begin
                    next_s.count = '0;
                    if (cal_req_i) begin
                        next_s.phase    = PH_CAL_OFS;
                        next_s.short_in = 1'b1;
                    end else begin
                        next_s.phase   = PH_IDLE;
                        next_s.ready_n = 1'b0;
                    end
                end
                PH_CAL_OFS: begin
                    next_s.count = s.count + 19'h1;
                    if (s.count == CAL_HALF_M1) begin
                        next_s.corr.offset = raw_sample_i;
                        next_s.short_in    = 1'b0;
                        next_s.ref_in      = 1'b1;
                        next_s.count       = '0;
                        next_s.phase       = PH_CAL_GAIN;
                    end
                end
                PH_CAL_GAIN: begin
                    next_s.count = s.count + 19'h1;
                    if (s.count == CAL_HALF_M1) begin
                        next_s.corr.gain  = new_gain;
                        next_s.ref_in     = 1'b0;
                        next_s.count      = '0;
                        next_s.phase      = PH_IDLE;
                        next_s.ready_n    = 1'b0;
                        next_s.calibrated = 1'b1;
                    end
                end
                PH_IDLE: begin
                    next_s.count = '0;
                    if (cal_req_i && !s.cal_prev) begin
                        next_s.phase    = PH_CAL_OFS;
                        next_s.short_in = 1'b1;
                    end else if (!start_sample_n_i) begin
                        next_s.phase = PH_ARM;
                    end
                end
                PH_ARM: begin
                    next_s.phase = PH_SAMPLE;
                    next_s.count = '0;
                end
                PH_SAMPLE: begin
                    next_s.count = s.count + 19'h1;
                    if (s.count == LEAD_AT && !chip_select_n_i
                        && !s.ready_n) begin
                        next_s.ready_n = 1'b1;
                    end
                    if (s.count == SAMPLE_M1) begin
                        next_s.result  = code;
                        next_s.ready_n = 1'b0;
                        next_s.count   = '0;
                        if (start_sample_n_i) begin
                            next_s.phase = PH_IDLE;
                        end else begin
                            next_s.phase = PH_SAMPLE;
                        end
                    end
                end
                default: begin
                    next_s = RESET_ST;
                end
            endcase
        end
        next_s.busy = (next_s.phase != PH_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= RESET_ST;
        end else begin
            s <= next_s;
        end
    end

    assign data_ready_n_o = s.ready_n;
    assign result_o       = s.result;
    assign short_inputs_o = s.short_in;
    assign ref_to_input_o = s.ref_in;
    assign calibrated_o   = s.calibrated;
    assign busy_o         = s.busy;

    // helper: cycles spent calibrating
    logic [19:0] cal_len;
    logic        in_cal;

    assign in_cal = (s.phase == PH_CAL_OFS) || (s.phase == PH_CAL_GAIN);

    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cal_len <= '0;
        end else if (!in_cal) begin
            cal_len <= '0;
        end else if (!clock_hold) begin
            cal_len <= cal_len + 20'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_sync_n);

    a_reset_values : assert property (
        s.phase == PH_RESET |-> s.corr.offset == `ACS_OFFSET_RESET
            && s.corr.gain == `ACS_GAIN_UNITY)
        else $error("corrections not at reset values");

    a_no_strap_cal : assert property (
        (s.phase == PH_RESET && !cal_req_i && !clock_hold)
            |=> s.phase == PH_IDLE && !data_ready_n_o && !short_inputs_o)
        else $error("reset without strap did not go idle");

    a_strap_cal : assert property (
        (s.phase == PH_RESET && cal_req_i && !clock_hold)
            |=> short_inputs_o && s.phase == PH_CAL_OFS)
        else $error("strapped calibration did not start");

    a_cal_length : assert property (
        $fell(ref_to_input_o) |-> cal_len == CAL_TOTAL
            && !data_ready_n_o)
        else $error("calibration length or ready wrong");

    a_cal_order : assert property (
        $rose(ref_to_input_o) |-> $past(short_inputs_o)
            && !short_inputs_o && s.corr.offset == $past(raw_sample_i))
        else $error("gain step not preceded by offset step");

    a_idle_cal : assert property (
        (s.phase == PH_IDLE && cal_req_i && !s.cal_prev && !clock_hold)
            |=> s.phase == PH_CAL_OFS ##1 short_inputs_o)
        else $error("idle calibrate request ignored");

    a_start_arm : assert property (
        (s.phase == PH_IDLE && !start_sample_n_i && !clock_hold
            && !(cal_req_i && !s.cal_prev))
            |=> s.phase == PH_ARM)
        else $error("start request not armed");

    a_back_to_back : assert property (
        (s.phase == PH_SAMPLE && s.count == SAMPLE_M1 && !clock_hold
            && !start_sample_n_i)
            |=> s.phase == PH_SAMPLE && s.count == '0 && !data_ready_n_o)
        else $error("continuous conversion broke");

    a_result_load : assert property (
        (s.phase == PH_SAMPLE && s.count == SAMPLE_M1 && !clock_hold)
            |=> !data_ready_n_o && result_o == $past(code))
        else $error("result not loaded at end");

    a_ready_lead : assert property (
        (s.phase == PH_SAMPLE && s.count == LEAD_AT && !clock_hold
            && !chip_select_n_i && !data_ready_n_o && !word_read_i)
            |=> data_ready_n_o)
        else $error("ready did not rise before end");

    a_cal_holdoff : assert property (
        in_cal |=> s.phase != PH_ARM && s.phase != PH_SAMPLE)
        else $error("conversion started during calibration");

    a_suspend : assert property (
        clock_hold |=> s.phase == $past(s.phase)
            && s.count == $past(s.count))
        else $error("state advanced while suspended");

    a_short_length : assert property (
        $fell(short_inputs_o) |-> cal_len == CAL_HALF
            && ref_to_input_o)
        else $error("offset step length wrong");

    a_path_exclusive : assert property (
        !(short_inputs_o && ref_to_input_o))
        else $error("short and reference selected together");

    a_cal_flag : assert property (
        $rose(calibrated_o) |-> $past(s.phase) == PH_CAL_GAIN
            && s.phase == PH_IDLE)
        else $error("calibrated flag set outside gain end");

    a_gain_store : assert property (
        (s.phase == PH_CAL_GAIN && s.count == CAL_HALF_M1 && !clock_hold)
            |=> s.corr.gain == $past(new_gain)
            && s.corr.offset == $past(s.corr.offset))
        else $error("gain correction not stored");

    a_single_stop : assert property (
        (s.phase == PH_SAMPLE && s.count == SAMPLE_M1 && !clock_hold
            && start_sample_n_i)
            |=> s.phase == PH_IDLE && !data_ready_n_o)
        else $error("single conversion did not stop");

    a_corr_frozen : assert property (
        !in_cal |=> $stable(s.corr))
        else $error("corrections changed outside calibration");

    a_count_bound : assert property (
        s.phase == PH_SAMPLE |-> s.count <= SAMPLE_M1)
        else $error("conversion counter out of range");

    a_arm_sample : assert property (
        (s.phase == PH_ARM && !clock_hold)
            |=> s.phase == PH_SAMPLE && s.count == '0)
        else $error("armed conversion did not start");

    a_ready_by_read : assert property (
        (word_read_i && !data_ready_n_o && s.phase == PH_IDLE)
            |=> data_ready_n_o)
        else $error("ready did not rise after read");

    a_result_hold : assert property (
        s.phase != PH_SAMPLE |=> $stable(result_o))
        else $error("result changed outside conversion");

    a_uncal_values : assert property (
        (!calibrated_o && s.phase != PH_CAL_GAIN)
            |-> s.corr.offset == `ACS_OFFSET_RESET
            && s.corr.gain == `ACS_GAIN_UNITY)
        else $error("uncalibrated corrections not at reset values");

    a_run_to_end : assert property (
        (s.phase == PH_SAMPLE && s.count != SAMPLE_M1 && !clock_hold)
            |=> s.phase == PH_SAMPLE
            && s.count == $past(s.count) + 19'h1)
        else $error("conversion cut short");
endmodule

// ===== verification/acs_host_model.sv
// Purpose: host and analogue front end seen by the sequencer
// Assumes: bench sets the command levels at rising edges
// Notes:   reader empties the port one cycle after ready is seen low
`timescale 1ns/1ps
module acs_host_model (
    input  wire logic        clk_i,
    input  wire logic        hold_low_i,
    input  wire logic        auto_read_i,
    input  wire logic        data_ready_n_i,
    input  wire logic        short_i,
    input  wire logic        ref_i,
    input  wire logic [15:0] start_sample_n_raw_i,
    input  wire logic [15:0] ofs_raw_i,
    input  wire logic [15:0] gain_raw_i,
    output logic             start_sample_n_o,
    output logic             word_read_o,
    output logic [15:0]      raw_sample_o
);
    assign start_sample_n_o = ~hold_low_i;
    assign raw_sample_o = short_i ? ofs_raw_i :
                          ref_i ? gain_raw_i : start_sample_n_raw_i;

    initial begin
        word_read_o = 1'b0;
    end

    // one read pulse while ready stays low
    always @(posedge clk_i) begin
        word_read_o <= auto_read_i && !data_ready_n_i && !word_read_o;
    end
endmodule

// ===== verification/test_adc_conversion_calibration_sequencer.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: calibration shortened to 16 cycles
// Notes:   stimulus changes only at rising edges
`timescale 1ns/1ps
module test_adc_conversion_calibration_sequencer;
    import acs_pkg::*;
    localparam int CAL  = 16;
    localparam int HOLD = 8;
    logic        clk_i, rst_n_i, cal_req_i, sel, cs_n, mclk;
    logic        hold_low, auto_read;
    logic [15:0] start_sample_n_raw, ofs_raw, gain_raw;
    logic        start_n, word_read, ready_n, short_in, ref_in;
    logic        osc_en, calibrated, busy;
    logic [15:0] raw, result;
    int          err_total, checks, cyc, n, m;

    acs_host_model host (
        .clk_i(clk_i), .hold_low_i(hold_low), .auto_read_i(auto_read),
        .data_ready_n_i(ready_n), .short_i(short_in), .ref_i(ref_in),
        .start_sample_n_raw_i(start_sample_n_raw), .ofs_raw_i(ofs_raw),
        .gain_raw_i(gain_raw), .start_sample_n_o(start_n),
        .word_read_o(word_read), .raw_sample_o(raw));

    acs_sequencer #(.CAL_CYCLES(CAL), .HOLD_CYCLES(HOLD)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cal_req_i(cal_req_i),
        .start_sample_n_i(start_n), .signed_range_select_i(sel),
        .chip_select_n_i(cs_n), .word_read_i(word_read),
        .raw_sample_i(raw), .mclk_pin_i(mclk),
        .data_ready_n_o(ready_n), .result_o(result),
        .short_inputs_o(short_in), .ref_to_input_o(ref_in),
        .osc_enable_o(osc_en), .calibrated_o(calibrated), .busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic complete_run();
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic cmp_word(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic cmp_bit(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %b seen %b", what, exp, got);
            err_total++;
        end
    endtask

    task automatic tick(int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // edges until ready is seen high and then low again
    task automatic wait_low(output int k);
        k = 0;
        do begin
            tick(1);
            k++;
        end while (ready_n !== 1'b1 && k < 2000);
        do begin
            tick(1);
            k++;
        end while (ready_n !== 1'b0 && k < 2000);
    endtask

    task automatic t_reset(logic strap);
        @(posedge clk_i) rst_n_i <= 1'b0;
        cal_req_i <= strap;
        tick(3);
        @(posedge clk_i) rst_n_i <= 1'b1;
        tick(3);
        cmp_bit("short at release", strap, short_in);
        cmp_bit("ready at release", strap, ready_n);
        cmp_bit("calibrated", 1'b0, calibrated);
        if (strap) begin
            tick(CAL);
            cmp_bit("ready after strap cal", 1'b0, ready_n);
            cmp_bit("calibrated strap", 1'b1, calibrated);
        end
        @(posedge clk_i) cal_req_i <= 1'b0;
        tick(4);
    endtask

    task automatic t_single();
        @(posedge clk_i) hold_low <= 1'b1;
        tick(9);
        @(posedge clk_i) hold_low <= 1'b0;
        wait_low(n);
        cmp_word("single latency", 16'h00A2, 16'(n + 10));
        cmp_word("unity result", 16'h1234, result);
        tick(4);
        cmp_bit("ready after read", 1'b1, ready_n);
        tick(200);
        cmp_bit("no second result", 1'b1, ready_n);
        cmp_bit("idle", 1'b0, busy);
    endtask

    task automatic t_continuous();
        @(posedge clk_i) sel <= 1'b0;
        start_sample_n_raw <= 16'h0100;
        hold_low <= 1'b1;
        auto_read <= 1'b0;
        cs_n <= 1'b0;
        wait_low(n);
        wait_low(m);
        cmp_word("continuous period", 16'h00A0, 16'(m));
        cmp_word("unipolar code", 16'h8100, result);
        tick(157);
        cmp_bit("ready before lead", 1'b0, ready_n);
        tick(1);
        cmp_bit("early rise", 1'b1, ready_n);
        tick(2);
        cmp_bit("reload fall", 1'b0, ready_n);
        @(posedge clk_i) hold_low <= 1'b0;
        auto_read <= 1'b1;
        cs_n <= 1'b1;
        sel <= 1'b1;
        wait_low(n);
        tick(4);
    endtask

    task automatic t_calibrate();
        @(posedge clk_i) cal_req_i <= 1'b1;
        hold_low <= 1'b1;
        start_sample_n_raw <= 16'h8000;
        tick(2);
        cmp_bit("offset phase", 1'b1, short_in);
        cmp_bit("no ref yet", 1'b0, ref_in);
        tick(CAL / 2);
        cmp_bit("gain phase", 1'b1, ref_in);
        cmp_bit("short done", 1'b0, short_in);
        tick(CAL / 2 - 2);
        cmp_bit("start held off", 1'b1, ready_n);
        tick(1);
        cmp_bit("cal ready fall", 1'b0, ready_n);
        cmp_bit("calibrated", 1'b1, calibrated);
        @(posedge clk_i) cal_req_i <= 1'b0;
        wait_low(n);
        cmp_word("start after cal", 16'h00A1, 16'(n));
        cmp_word("clamped result", 16'h8000, result);
        @(posedge clk_i) hold_low <= 1'b0;
        wait_low(n);
        tick(4);
    endtask

    task automatic t_clock_hold();
        cmp_bit("oscillator on", 1'b1, osc_en);
        @(posedge clk_i) hold_low <= 1'b1;
        tick(9);
        @(posedge clk_i) hold_low <= 1'b0;
        mclk <= 1'b1;
        tick(30);
        cmp_bit("oscillator stopped", 1'b0, osc_en);
        @(posedge clk_i) mclk <= 1'b0;
        wait_low(n);
        cmp_bit("suspended", 1'b1, (n + 41) > 163);
        tick(20);
    endtask

    initial begin
        err_total = 0;
        checks = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        cal_req_i = 1'b0;
        sel = 1'b1;
        cs_n = 1'b1;
        mclk = 1'b0;
        hold_low = 1'b0;
        auto_read = 1'b1;
        start_sample_n_raw = 16'h1234;
        ofs_raw = 16'h0010;
        gain_raw = 16'h7FFF;
        tick(10);
        t_reset(1'b0);
        t_single();
        t_continuous();
        t_calibrate();
        t_clock_hold();
        t_reset(1'b1);
        complete_run();
    end
endmodule
